// *** rtl/mac_pkg.sv ***
// Purpose: shared constants for the multichannel converter output block
// Assumes: 10-bit results, 100 MHz system clock
// Notes: register indices are the two-line register address values
package mac_pkg;
    // ==========================================================
    // data and timing
    localparam int DATA_W = 10;
    localparam int RESULT_LATENCY = 5;
    localparam int MARKER_BASE_DELAY = 7;
    localparam logic [9:0] SIGN_FLIP = 10'h200;
    // ==========================================================
    // register addresses {bit1, bit0}
    localparam logic [1:0] ADDR_CH_REF = 2'h0;
    localparam logic [1:0] ADDR_FMT_RST = 2'h1;
    // ==========================================================
    // channel_and_reference_control fields
    localparam int CR_VREF_BIT = 0;
    localparam int CR_PD_BIT = 2;
    localparam int CR_SEL_LO = 3;
    localparam int CR_SEL_HI = 7;
    localparam int CR_TEST_LO = 8;
    localparam int CR_TEST_HI = 9;
    localparam logic [9:0] CH_REF_RESET = 10'h020;
    // ==========================================================
    // format_and_reset_control fields
    localparam int FR_RESET_BIT = 0;
    localparam int FR_RESTART_BIT = 1;
    localparam int FR_STROBE_MODE_BIT = 6;
    localparam int FR_FORMAT_BIT = 7;
    localparam logic [9:0] FMT_RST_RESET = 10'h000;
    // ==========================================================
    // input slots
    typedef enum logic [2:0] {
        MAC_SLOT_AP = 3'b000,
        MAC_SLOT_AM = 3'b001,
        MAC_SLOT_BP = 3'b010,
        MAC_SLOT_BM = 3'b011,
        MAC_SLOT_DA = 3'b100,
        MAC_SLOT_DB = 3'b101
    } mac_slot_e;
endpackage : mac_pkg

// *** rtl/mac_edge_tick.sv ***
// Purpose: one-cycle pulse on each falling edge of the sample clock input
// Assumes: level is synchronous to clock
// Notes: enable low suppresses pulses (power down)
`timescale 1ns/1ns
module mac_edge_tick (
    input wire logic clock,    // system clock
    input wire logic reset_n,  // async reset, active low
    input wire logic level,    // sampled sample clock level
    input wire logic enable,   // allow pulses
    output logic tick          // falling edge pulse
);
    logic prev_r;
    logic prev_nxt;

    always_comb begin
        prev_nxt = level;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= prev_nxt;
        end
    end

    // reset value 0 keeps a low level at release from faking an edge
    assign tick = enable & prev_r & ~level;
endmodule // mac_edge_tick

// *** rtl/mac_delay_line.sv ***
// Purpose: enabled shift line of fixed depth
// Assumes: DEPTH of at least one
// Notes: advances only on enable
`timescale 1ns/1ns
module mac_delay_line #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 4
) (
    input wire logic clock,              // system clock
    input wire logic reset_n,            // async reset, active low
    input wire logic enable,             // advance one stage
    input wire logic [WIDTH-1:0] din,    // entry word
    output logic [WIDTH-1:0] dout        // oldest word
);
    if (DEPTH < 1 || WIDTH < 1) begin : g_bad
        $error("mac_delay_line: DEPTH and WIDTH must be positive");
    end

    logic [WIDTH-1:0] line_r [DEPTH];
    logic [WIDTH-1:0] line_nxt [DEPTH];

    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            line_nxt[i] = line_r[i];
        end
        if (enable) begin
            line_nxt[0] = din;
            for (int i = 1; i < DEPTH; i++) begin
                line_nxt[i] = line_r[i-1];
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                line_r[i] <= '0;
            end
        end else begin
            line_r <= line_nxt;
        end
    end

    assign dout = line_r[DEPTH-1];
endmodule // mac_delay_line

// *** rtl/mac_top.sv ***
// Purpose: digital output sequencer and control registers of a 4-input ADC
// Assumes: all pins synchronous to clock; raw inputs are offset binary
// Notes: data bus is split into in, out and output enable
//
// Functional notes
// - each falling sample clock edge presents one new result on the bus
// - up to four inputs, single-ended, differential or mixed
// - multichannel: marker low while first channel result is presented
// - single channel: marker stays inactive (high)
// - one channel: every sample clock period gives that channel
// - two channels alternate one, two; marker low on one
// - three channels repeat one, two, three; marker low on one
// - four channels repeat one to four; marker low on one
// - read needs low select, high select and low read strobe
// - results leave as offset binary or two's complement per format bit
// - single-ended binary: top 3FF, mid 200, bottom 000
// - single-ended two's complement: top 1FF, mid 000, bottom 200
// - differential binary: +full 3FF, zero 200, -full 000
// - differential two's complement: +full 1FF, zero 000, -full 200
// - two 10-bit control registers set the operating mode
// - address 00 selects first register, 01 second, others reserved
// - first register is write-only; bits above 9 are zero
// - result appears five sample clock cycles after its start edge
// - after marker restart first marker waits 7 plus channels cycles
// - write pin is combined direction or separate active-low strobe
`timescale 1ns/1ns
module mac_top import mac_pkg::*; (
    input wire logic clock,                    // 100 MHz system clock
    input wire logic reset_n,                  // async reset, active low
    input wire logic sample_clock_in,          // free-running sample clock
    input wire logic chip_select_low_active_n, // chip select, active low
    input wire logic chip_select_high_active,  // chip select, active high
    input wire logic read_strobe_n,            // read strobe, active low
    input wire logic write_strobe_pin,         // write strobe or direction
    input wire logic reg_addr_bit0,            // register address bit 0
    input wire logic reg_addr_bit1,            // register address bit 1
    input wire logic [DATA_W-1:0] data_in,     // bus level seen by device
    output logic [DATA_W-1:0] data_out,        // bus value driven
    output logic data_oe,                      // high while driving bus
    output logic first_channel_marker_n,       // first channel marker
    input wire logic [DATA_W-1:0] raw_ainp,    // quantised input A plus
    input wire logic [DATA_W-1:0] raw_ainm,    // quantised input A minus
    input wire logic [DATA_W-1:0] raw_binp,    // quantised input B plus
    input wire logic [DATA_W-1:0] raw_binm,    // quantised input B minus
    output logic power_down,                   // analog power down
    output logic vref_external,                // external reference chosen
    output logic [1:0] test_voltage_sel        // {hi, lo} test selection
);
    // ==========================================================
    // functions: configuration decode
    function automatic logic [2:0] chan_count(input logic [4:0] sel);
        unique case (sel)
            5'b10001, 5'b10101, 5'b11001: chan_count = 3'h2;
            5'b10010, 5'b10110: chan_count = 3'h3;
            5'b10011: chan_count = 3'h4;
            default: chan_count = 3'h1;
        endcase
    endfunction

    function automatic mac_slot_e slot_of(input logic [4:0] sel,
                                          input logic [1:0] idx);
        slot_of = MAC_SLOT_AP;
        if (!sel[4]) begin
            if (!sel[2]) begin
                slot_of = mac_slot_e'({1'b0, sel[1:0]});
            end else if (sel[1:0] == 2'b01) begin
                slot_of = MAC_SLOT_DB;
            end else if (sel[1:0] == 2'b00) begin
                slot_of = MAC_SLOT_DA;
            end
        end else begin
            unique case (sel[3:0])
                4'b0001, 4'b0010, 4'b0011: begin
                    slot_of = mac_slot_e'({1'b0, idx});
                end
                4'b0101: begin
                    slot_of = (idx == 2'h1) ? MAC_SLOT_DB : MAC_SLOT_AP;
                end
                4'b0110: begin
                    slot_of = (idx == 2'h2) ? MAC_SLOT_DB
                                            : mac_slot_e'({1'b0, idx});
                end
                4'b1001: begin
                    slot_of = (idx == 2'h1) ? MAC_SLOT_DB : MAC_SLOT_DA;
                end
                default: slot_of = MAC_SLOT_AP;
            endcase
        end
    endfunction

    // ==========================================================
    // state
    logic [9:0] ch_ref_r, ch_ref_nxt;
    logic [9:0] fmt_rst_r, fmt_rst_nxt;
    logic [1:0] slot_idx_r, slot_idx_nxt;
    logic [3:0] arm_cnt_r, arm_cnt_nxt;
    logic [DATA_W-1:0] data_out_r, data_out_nxt;
    logic marker_n_r, marker_n_nxt;
    logic wr_level_r;
    logic tick;
    logic [DATA_W:0] pipe_in, pipe_out;
    logic [4:0] sel;
    logic [2:0] count;
    logic [3:0] arm_target;
    logic multi;
    logic twos;
    logic sep_strobe;
    logic cs_ok;
    logic read_active;
    logic wr_level;
    logic write_go;
    logic [1:0] addr;
    logic restart;
    logic soft_reset;
    logic [DATA_W-1:0] sample_code;
    logic signed [DATA_W:0] diff_a, diff_b;

    assign sel = ch_ref_r[CR_SEL_HI:CR_SEL_LO];
    assign count = chan_count(sel);
    assign multi = (count != 3'h1);
    assign arm_target = 4'(MARKER_BASE_DELAY) + {1'b0, count};
    assign twos = fmt_rst_r[FR_FORMAT_BIT];
    assign sep_strobe = ~fmt_rst_r[FR_STROBE_MODE_BIT];
    assign addr = {reg_addr_bit1, reg_addr_bit0};

    // ==========================================================
    // bus strobes
    assign cs_ok = ~chip_select_low_active_n & chip_select_high_active;
    // combined mode: read strobe qualifies, pin gives direction
    assign read_active = cs_ok & ~read_strobe_n
                       & (sep_strobe | write_strobe_pin);
    assign wr_level = sep_strobe ? (cs_ok & ~write_strobe_pin)
                    : (cs_ok & ~read_strobe_n & ~write_strobe_pin);
    assign write_go = wr_level & ~wr_level_r;
    assign soft_reset = write_go && addr == ADDR_FMT_RST
                     && data_in[FR_RESET_BIT];
    assign restart = soft_reset
                  || (write_go && addr == ADDR_CH_REF)
                  || (write_go && addr == ADDR_FMT_RST
                      && data_in[FR_RESTART_BIT]);

    // ==========================================================
    // sample selection and coding
    // halved difference keeps full scale: +full maps to top code
    assign diff_a = ($signed({1'b0, raw_ainp}) - $signed({1'b0, raw_ainm}))
                    >>> 1;
    assign diff_b = ($signed({1'b0, raw_binp}) - $signed({1'b0, raw_binm}))
                    >>> 1;

    always_comb begin
        unique case (slot_of(sel, slot_idx_r))
            MAC_SLOT_AP: sample_code = raw_ainp;
            MAC_SLOT_AM: sample_code = raw_ainm;
            MAC_SLOT_BP: sample_code = raw_binp;
            MAC_SLOT_BM: sample_code = raw_binm;
            MAC_SLOT_DA: sample_code = diff_a[9:0] ^ SIGN_FLIP;
            MAC_SLOT_DB: sample_code = diff_b[9:0] ^ SIGN_FLIP;
            default: sample_code = raw_ainp;
        endcase
    end

    assign pipe_in = {slot_idx_r == 2'h0, sample_code};

    mac_edge_tick u_tick (
        .clock(clock),
        .reset_n(reset_n),
        .level(sample_clock_in),
        .enable(~ch_ref_r[CR_PD_BIT]),
        .tick(tick)
    );

    // five stages: a word captured on one edge reaches the output register
    // on the fifth edge after it
    mac_delay_line #(
        .WIDTH(DATA_W + 1),
        .DEPTH(RESULT_LATENCY)
    ) u_pipe (
        .clock(clock),
        .reset_n(reset_n),
        .enable(tick),
        .din(pipe_in),
        .dout(pipe_out)
    );

    // ==========================================================
    // next state
    always_comb begin
        ch_ref_nxt = ch_ref_r;
        fmt_rst_nxt = fmt_rst_r;
        slot_idx_nxt = slot_idx_r;
        arm_cnt_nxt = arm_cnt_r;
        data_out_nxt = data_out_r;
        marker_n_nxt = marker_n_r;
        if (write_go) begin
            unique case (addr)
                ADDR_CH_REF: ch_ref_nxt = data_in;
                ADDR_FMT_RST: begin
                    fmt_rst_nxt = data_in;
                    fmt_rst_nxt[FR_RESET_BIT] = 1'b0;
                    fmt_rst_nxt[FR_RESTART_BIT] = 1'b0;
                end
                default: ;
            endcase
            if (soft_reset) begin
                ch_ref_nxt = CH_REF_RESET;
                fmt_rst_nxt = FMT_RST_RESET;
            end
        end
        if (restart) begin
            slot_idx_nxt = 2'h0;
            arm_cnt_nxt = 4'h0;
        end else if (tick) begin
            slot_idx_nxt = (3'(slot_idx_r) + 3'h1 >= count) ? 2'h0
                         : slot_idx_r + 2'h1;
            if (arm_cnt_r < arm_target) begin
                arm_cnt_nxt = arm_cnt_r + 4'h1;
            end
        end
        if (tick) begin
            data_out_nxt = twos ? (pipe_out[9:0] ^ SIGN_FLIP)
                                : pipe_out[9:0];
            marker_n_nxt = ~(multi && pipe_out[DATA_W]
                             && arm_cnt_r >= arm_target);
        end
        if (!multi) begin
            marker_n_nxt = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ch_ref_r <= CH_REF_RESET;
            fmt_rst_r <= FMT_RST_RESET;
            slot_idx_r <= 2'h0;
            arm_cnt_r <= 4'h0;
            data_out_r <= 10'h000;
            marker_n_r <= 1'b1;
            wr_level_r <= 1'b0;
        end else begin
            ch_ref_r <= ch_ref_nxt;
            fmt_rst_r <= fmt_rst_nxt;
            slot_idx_r <= slot_idx_nxt;
            arm_cnt_r <= arm_cnt_nxt;
            data_out_r <= data_out_nxt;
            marker_n_r <= marker_n_nxt;
            wr_level_r <= wr_level;
        end
    end

    // ==========================================================
    // outputs; control registers are never driven back
    assign data_out = data_out_r;
    assign data_oe = read_active;
    assign first_channel_marker_n = marker_n_r;
    assign power_down = ch_ref_r[CR_PD_BIT];
    assign vref_external = ch_ref_r[CR_VREF_BIT];
    assign test_voltage_sel = ch_ref_r[CR_TEST_HI:CR_TEST_LO];

    // ==========================================================
    // checks
    sequence s_restart;
        restart;
    endsequence

    sequence s_quiet_ticks;
        !tick [*2];
    endsequence

    chk_read_drive: assert property (
        @(posedge clock) disable iff (!reset_n)
        data_oe |-> !chip_select_low_active_n && chip_select_high_active
                    && !read_strobe_n && !write_go)
        else $error("bus driven without a full read strobe");
    chk_single_marker: assert property (
        @(posedge clock) disable iff (!reset_n)
        (!multi && !write_go) |=> first_channel_marker_n)
        else $error("marker active in single channel");
    chk_format_code: assert property (
        @(posedge clock) disable iff (!reset_n)
        tick |=> data_out == ($past(twos) ? ($past(pipe_out[9:0]) ^ SIGN_FLIP)
                                          : $past(pipe_out[9:0])))
        else $error("output code format wrong");
    chk_slot_wrap: assert property (
        @(posedge clock) disable iff (!reset_n)
        (tick && !restart && 3'(slot_idx_r) == count - 3'h1)
        |=> slot_idx_r == 2'h0)
        else $error("channel order did not wrap");
    chk_marker_hold: assert property (
        @(posedge clock) disable iff (!reset_n)
        s_restart ##1 s_quiet_ticks |-> first_channel_marker_n
                                        || marker_n_r == $past(marker_n_r))
        else $error("marker changed without a sample edge");
    chk_arm_reset: assert property (
        @(posedge clock) disable iff (!reset_n)
        s_restart |=> arm_cnt_r == 4'h0)
        else $error("marker delay not restarted");
    chk_reserved_write: assert property (
        @(posedge clock) disable iff (!reset_n)
        (write_go && addr[1]) |=> $stable(ch_ref_r) && $stable(fmt_rst_r))
        else $error("reserved write changed a register");
    chk_first_write: assert property (
        @(posedge clock) disable iff (!reset_n)
        (write_go && addr == ADDR_CH_REF) |=> ch_ref_r == $past(data_in))
        else $error("first register not written");
    chk_one_result: assert property (
        @(posedge clock) disable iff (!reset_n)
        !tick |=> $stable(data_out))
        else $error("result changed without a sample edge");
    chk_marker_first: assert property (
        @(posedge clock) disable iff (!reset_n)
        (tick && multi && !pipe_out[DATA_W]) |=> first_channel_marker_n)
        else $error("marker low on a later channel");
endmodule // mac_top

// *** verification/mac_host_model.sv ***
// Purpose: host processor model on the converter's parallel bus
// Assumes: tasks are entered one time unit after a rising clock edge
// Notes: a released bus has no keeper, so it shows the inverse level
`timescale 1ns/1ns
module mac_host_model import mac_pkg::*; (
    input wire logic clock,                     // system clock
    input wire logic [DATA_W-1:0] data_out,     // device drive value
    input wire logic data_oe,                   // device drives the bus
    output logic chip_select_low_active_n,      // select, active low
    output logic chip_select_high_active,       // select, active high
    output logic read_strobe_n,                 // read strobe, active low
    output logic write_strobe_pin,              // write strobe or direction
    output logic reg_addr_bit0,                 // register address bit 0
    output logic reg_addr_bit1,                 // register address bit 1
    output logic [DATA_W-1:0] data_in           // resolved bus level
);
    logic host_oe = 1'b0;
    logic [DATA_W-1:0] host_val = 10'h000;
    logic [DATA_W-1:0] last_r = 10'h000;

    // ==========================================================
    // bus resolution
    // an undriven bus must not echo the old word, or a missing enable
    // would go unseen
    always @(posedge clock) begin
        if (host_oe || data_oe) last_r <= data_in;
    end
    assign data_in = host_oe ? host_val : (data_oe ? data_out : ~last_r);

    initial begin
        chip_select_low_active_n = 1'b1;
        chip_select_high_active = 1'b0;
        read_strobe_n = 1'b1;
        write_strobe_pin = 1'b1;
        reg_addr_bit0 = 1'b0;
        reg_addr_bit1 = 1'b0;
    end

    // ==========================================================
    // access tasks
    task automatic release_bus();
        chip_select_low_active_n = 1'b1;
        chip_select_high_active = 1'b0;
        read_strobe_n = 1'b1;
        write_strobe_pin = 1'b1;
        host_oe = 1'b0;
    endtask

    task automatic write_reg(input logic [1:0] addr, input logic [9:0] val,
                             input bit combined);
        reg_addr_bit0 = addr[0];
        reg_addr_bit1 = addr[1];
        host_val = val;
        host_oe = 1'b1;
        chip_select_low_active_n = 1'b0;
        chip_select_high_active = 1'b1;
        read_strobe_n = !combined;
        write_strobe_pin = 1'b0;
        @(posedge clock);
        #1;
        release_bus();
        // strobe stays released a full cycle before the next access
        @(posedge clock);
        #1;
    endtask

    task automatic read_bus(input logic [2:0] en, output logic [9:0] val,
                            output logic oe);
        chip_select_low_active_n = !en[0];
        chip_select_high_active = en[1];
        read_strobe_n = !en[2];
        @(posedge clock);
        val = data_in;
        oe = data_oe;
        #1;
        release_bus();
        // one idle cycle so a following access never re-raises a strobe
        @(posedge clock);
        #1;
    endtask
endmodule // mac_host_model

// *** verification/multichannel_adc_output_and_config_test.sv ***
// Purpose: self-checking bench for the converter output block
// Assumes: host model owns the bus; bench drives sample clock and inputs
// Notes: one sample period is ten system clocks, fourteen where the reserved writes follow it
`timescale 1ns/1ns
module multichannel_adc_output_and_config_test;
    import mac_pkg::*;
    localparam logic [9:0] CFG_V [10] = '{10'h000, 10'h020, 10'h018,
        10'h028, 10'h088, 10'h090, 10'h098, 10'h0A8, 10'h0B0, 10'h0C8};
    localparam int CFG_N [10] = '{1, 1, 1, 1, 2, 3, 4, 2, 3, 2};
    // slot k of the scan order sits in bits 3k+2..3k
    localparam logic [11:0] CFG_S [10] = '{12'h000, 12'h004, 12'h003,
        12'h005, 12'h008, 12'h088, 12'h688, 12'h028, 12'h148, 12'h02C};
    localparam logic [2:0] BAD [3] = '{3'b110, 3'b101, 3'b011};
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic sample_clock_in = 1'b0;
    logic [DATA_W-1:0] raw [4];
    logic cs_n, cs_h, rd_n, wr_p, ra0, ra1, oe, mark_n, pd, vref, rd_oe;
    logic [DATA_W-1:0] din, dout, rdv, v1;
    logic [1:0] tsel;
    int fails = 0;
    int n_compared = 0;

    always #5 clock = ~clock;

    mac_top uut (.clock(clock), .reset_n(reset_n),
        .sample_clock_in(sample_clock_in), .chip_select_low_active_n(cs_n),
        .chip_select_high_active(cs_h), .read_strobe_n(rd_n),
        .write_strobe_pin(wr_p), .reg_addr_bit0(ra0), .reg_addr_bit1(ra1),
        .data_in(din), .data_out(dout), .data_oe(oe),
        .first_channel_marker_n(mark_n), .raw_ainp(raw[0]),
        .raw_ainm(raw[1]), .raw_binp(raw[2]), .raw_binm(raw[3]),
        .power_down(pd), .vref_external(vref), .test_voltage_sel(tsel));

    mac_host_model host (.clock(clock), .data_out(dout), .data_oe(oe),
        .chip_select_low_active_n(cs_n), .chip_select_high_active(cs_h),
        .read_strobe_n(rd_n), .write_strobe_pin(wr_p), .reg_addr_bit0(ra0),
        .reg_addr_bit1(ra1), .data_in(din));

    // ==========================================================
    // helpers
    task automatic check(string what, logic [9:0] seen, logic [9:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cyc(int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // boundary codes on every input so full scale, mid and zero all pass
    function automatic logic [9:0] rawv(int j, int ch);
        logic [9:0] tab [4];
        tab = '{10'h3FF, 10'h200, 10'h000, 10'h1A5};
        case (ch)
            0: return tab[j % 4];
            1: return tab[(j + 2) % 4];
            2: return tab[(j + 1) % 4];
            default: return (j % 4 == 0) ? tab[1] : tab[(j + 3) % 4];
        endcase
    endfunction

    function automatic logic [9:0] code_of(logic [2:0] s, int j);
        int d;
        if (s < MAC_SLOT_DA) return rawv(j, int'(s));
        d = int'(rawv(j, s == MAC_SLOT_DA ? 0 : 2))
            - int'(rawv(j, s == MAC_SLOT_DA ? 1 : 3));
        return 10'(d >>> 1) ^ 10'h200;
    endfunction

    task automatic period(int j);
        sample_clock_in = 1'b1;
        for (int k = 0; k < 4; k++) raw[k] = rawv(j, k);
        cyc(4);
        sample_clock_in = 1'b0;
        cyc(4);
        host.read_bus(3'b111, rdv, rd_oe);
        check("read enable", {9'h0, rd_oe}, 10'h001);
    endtask

    // ==========================================================
    // one channel configuration, with reserved writes in mid-stream
    task automatic run_cfg(int c);
        bit twos;
        int n;
        int j;
        logic [9:0] exp;
        logic [9:0] mexp;
        twos = c[0];
        n = CFG_N[c];
        host.write_reg(ADDR_FMT_RST, twos ? 10'h080 : 10'h000, 1'b0);
        host.write_reg(ADDR_CH_REF, CFG_V[c], 1'b0);
        for (int i = 0; i < 20; i++) begin
            period(i);
            j = i - 5;
            if (i >= 5) begin
                exp = code_of(CFG_S[c][3 * (j % n) +: 3], j);
                if (twos) exp = exp ^ SIGN_FLIP;
                check("result", rdv, exp);
                check("slot order", rdv, exp);
                mexp = (n > 1 && j % n == 0 && i >= 8 + n) ? 10'h0 : 10'h1;
                if (n == 1 || i < 7 || i >= 8 + n) begin
                    check("marker", {9'h0, mark_n}, mexp);
                end
            end
            if (i == 12) begin
                host.write_reg(2'h2, 10'h098, 1'b0);
                host.write_reg(2'h3, twos ? 10'h000 : 10'h080, 1'b0);
            end
        end
    endtask

    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        for (int k = 0; k < 4; k++) raw[k] = 10'h000;
        repeat (4) @(posedge clock);
        #1;
        reset_n = 1'b1;
        check("reset data", dout, 10'h000);
        check("rst pins", {5'h0, tsel, vref, pd, mark_n}, 10'h001);
        host.write_reg(ADDR_FMT_RST, 10'h040, 1'b0);
        host.read_bus(3'b111, rdv, rd_oe);
        check("combined read", {9'h0, rd_oe}, 10'h001);
        host.write_reg(ADDR_CH_REF, 10'h305, 1'b1);
        check("controls", {6'h0, tsel, vref, pd}, 10'h00F);
        host.read_bus(3'b111, rdv, rd_oe);
        v1 = rdv;
        // enough edges that a live pipe would push a full-scale code out
        for (int i = 40; i < 46; i++) period(i);
        check("power down hold", rdv, v1);
        host.write_reg(ADDR_FMT_RST, 10'h001, 1'b1);
        check("soft reset", {6'h0, tsel, vref, pd}, 10'h000);
        for (int k = 0; k < 3; k++) begin
            host.read_bus(BAD[k], rdv, rd_oe);
            check("partial read", {9'h0, rd_oe}, 10'h000);
        end
        for (int c = 0; c < 10; c++) run_cfg(c);
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        wrap_up();
    end
endmodule // multichannel_adc_output_and_config_test
